// ==== rtl/spd_top.v ====
// slave controller port write decode and init word sequencer
// assumes host port strobes are synchronous to mclk_in; one write per strobe cycle
`timescale 1ns/1ps
`include "spd_map.vh"

module spd_top (
  input wire mclk_in,
  input wire rst_b_in,
  input wire ce_in,
  input wire wr_stb_in,
  input wire rd_stb_in,
  input wire [15:0] addr_in,
  input wire [7:0] wdata_in,
  input wire slave_cascade_enable_in,
  input wire [7:0] request_register_in,
  input wire [7:0] in_service_register_in,
  output reg [7:0] rdata_out,
  output reg [7:0] init_word_1_out,
  output reg [7:0] init_word_2_out,
  output reg [7:0] init_word_3_out,
  output reg [7:0] init_word_4_out,
  output reg [7:0] operation_word_2_out,
  output reg [7:0] operation_word_3_out,
  output reg init_busy_out,
  output reg [1:0] init_ptr_out,
  output reg special_mask_out,
  output reg poll_req_out,
  output reg rot_clr_out,
  output reg ns_eoi_out,
  output reg sp_eoi_out,
  output reg rot_set_out,
  output reg rot_ns_out,
  output reg set_pri_out,
  output reg rot_sp_out,
  output reg [7:0] level_onehot_out
);

  // -------------------------------------------------
  // pointer states
  // -------------------------------------------------
  localparam [1:0] seq_idle = `SPD_SEQ_IDLE;
  localparam [1:0] seq_w2 = `SPD_SEQ_W2;
  localparam [1:0] seq_w3 = `SPD_SEQ_W3;
  localparam [1:0] seq_w4 = `SPD_SEQ_W4;

  // -------------------------------------------------
  // decode of the write strobe
  // -------------------------------------------------
  wire live;
  wire base_wr;
  wire second_wr;
  wire wr_init1;
  wire wr_op2;
  wire wr_op3;
  wire fourth_flag;
  reg read_isr;
  reg [1:0] next_ptr;
  reg next_busy;
  wire c_rot_clr;
  wire c_ns_eoi;
  wire c_sp_eoi;
  wire c_rot_set;
  wire c_rot_ns;
  wire c_set_pri;
  wire c_rot_sp;
  wire [7:0] c_lvl;

  // bypassed slave ignores every control write
  assign live = ce_in & slave_cascade_enable_in;
  assign base_wr = live & wr_stb_in & (addr_in == `SPD_PORT_BASE);
  assign second_wr = live & wr_stb_in & (addr_in == `SPD_PORT_SECOND);
  assign wr_init1 = base_wr & wdata_in[`SPD_BIT_INIT_SEL];
  assign wr_op2 = base_wr & ~wdata_in[`SPD_BIT_INIT_SEL] & ~wdata_in[`SPD_BIT_OP3_SEL];
  assign wr_op3 = base_wr & ~wdata_in[`SPD_BIT_INIT_SEL] & wdata_in[`SPD_BIT_OP3_SEL];
  assign fourth_flag = init_word_1_out[`SPD_BIT_FOURTH];

  spd_cmd_decode u_cmd (
    .wr_op2_in(wr_op2),
    .data_in(wdata_in),
    .rot_clr_out(c_rot_clr),
    .ns_eoi_out(c_ns_eoi),
    .sp_eoi_out(c_sp_eoi),
    .rot_set_out(c_rot_set),
    .rot_ns_out(c_rot_ns),
    .set_pri_out(c_set_pri),
    .rot_sp_out(c_rot_sp),
    .level_onehot_out(c_lvl)
  );

  // -------------------------------------------------
  // init pointer next state
  // -------------------------------------------------
  always @* begin
    next_ptr = init_ptr_out;
    next_busy = init_busy_out;
    if (wr_init1) begin
      next_ptr = seq_w2;
      next_busy = 1'b1;
    end else if (second_wr && init_busy_out) begin
      case (init_ptr_out)
        seq_w2: next_ptr = seq_w3;
        seq_w3: begin
          // single mode never exists, so word 3 is always taken
          if (fourth_flag) begin
            next_ptr = seq_w4;
          end else begin
            next_ptr = seq_idle;
            next_busy = 1'b0;
          end
        end
        seq_w4: begin
          next_ptr = seq_idle;
          next_busy = 1'b0;
        end
        default: next_ptr = seq_idle;
      endcase
    end
  end

  // -------------------------------------------------
  // sequencer registers
  // -------------------------------------------------
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      init_busy_out <= 1'b0;
      init_ptr_out <= seq_idle;
    end else if (ce_in) begin
      init_ptr_out <= next_ptr;
      init_busy_out <= next_busy;
    end
  end

  // -------------------------------------------------
  // initialization words
  // -------------------------------------------------
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      init_word_1_out <= `SPD_INIT1_RESET;
      init_word_2_out <= `SPD_WORD_RESET;
      init_word_3_out <= `SPD_WORD_RESET;
      init_word_4_out <= `SPD_INIT4_DEFAULT;
    end else if (ce_in) begin
      if (wr_init1) begin
        // single flag forced, vector interval bit kept as written
        init_word_1_out <= {wdata_in[7:2], `SPD_SINGLE_FLAG, wdata_in[0]};
        if (!wdata_in[`SPD_BIT_FOURTH])
          init_word_4_out <= `SPD_INIT4_DEFAULT;
      end
      // second-port writes outside a sequence are dropped silently
      if (second_wr && init_busy_out) begin
        if (init_ptr_out == seq_w2)
          init_word_2_out <= wdata_in;
        if (init_ptr_out == seq_w3)
          init_word_3_out <= wdata_in;
        if (init_ptr_out == seq_w4)
          init_word_4_out <= wdata_in;
      end
    end
  end

  // -------------------------------------------------
  // operation words and their side effects
  // -------------------------------------------------
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      operation_word_2_out <= `SPD_WORD_RESET;
      operation_word_3_out <= `SPD_WORD_RESET;
      read_isr <= 1'b0;
      special_mask_out <= 1'b0;
      poll_req_out <= 1'b0;
    end else if (ce_in) begin
      poll_req_out <= wr_op3 & wdata_in[`SPD_BIT_POLL];
      if (wr_op2)
        operation_word_2_out <= wdata_in;
      if (wr_op3) begin
        operation_word_3_out <= wdata_in;
        // read select moves only when bit 1 asks for it
        if (wdata_in[`SPD_BIT_READ_REG])
          read_isr <= wdata_in[`SPD_BIT_READ_ISR];
        if (wdata_in[`SPD_MASK_HI])
          special_mask_out <= wdata_in[`SPD_MASK_LO];
      end
    end
  end

  // -------------------------------------------------
  // command pulses, one cycle each
  // -------------------------------------------------
  // registered so decoder glitches never leave the block
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      rot_clr_out <= 1'b0;
      ns_eoi_out <= 1'b0;
      sp_eoi_out <= 1'b0;
      rot_set_out <= 1'b0;
      rot_ns_out <= 1'b0;
      set_pri_out <= 1'b0;
      rot_sp_out <= 1'b0;
      level_onehot_out <= `SPD_WORD_RESET;
    end else if (ce_in) begin
      rot_clr_out <= c_rot_clr;
      ns_eoi_out <= c_ns_eoi;
      sp_eoi_out <= c_sp_eoi;
      rot_set_out <= c_rot_set;
      rot_ns_out <= c_rot_ns;
      set_pri_out <= c_set_pri;
      rot_sp_out <= c_rot_sp;
      level_onehot_out <= c_lvl;
    end
  end

  // -------------------------------------------------
  // read path
  // -------------------------------------------------
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      rdata_out <= `SPD_WORD_RESET;
    end else if (ce_in) begin
      // registered on the strobe; selection kept until an op3 write with bit 1 set
      if (rd_stb_in && addr_in == `SPD_PORT_BASE)
        rdata_out <= read_isr ? in_service_register_in : request_register_in;
      else if (rd_stb_in)
        rdata_out <= `SPD_UNMAPPED_READ;
    end
  end

endmodule // spd_top

// ==== rtl/spd_map.vh ====
// constants for the slave interrupt controller write decode and init sequencing
// assumes a single 8-bit data bus with write and read strobes on one clock
`ifndef SPD_MAP_VH
`define SPD_MAP_VH

`define SPD_PORT_BASE 16'h00A0
`define SPD_PORT_SECOND 16'h00A1

`define SPD_BIT_INIT_SEL 4
`define SPD_BIT_OP3_SEL 3
`define SPD_BIT_FOURTH 0
`define SPD_BIT_SINGLE 1
`define SPD_BIT_READ_REG 1
`define SPD_BIT_READ_ISR 0
`define SPD_BIT_POLL 2
`define SPD_CMD_HI 7
`define SPD_CMD_LO 5
`define SPD_MASK_HI 6
`define SPD_MASK_LO 5

`define SPD_SINGLE_FLAG 1'b0
`define SPD_INIT4_DEFAULT 8'h01
`define SPD_INIT1_RESET 8'h14
`define SPD_WORD_RESET 8'h00
`define SPD_UNMAPPED_READ 8'h00

`define SPD_CMD_ROT_CLR 3'h0
`define SPD_CMD_NS_EOI 3'h1
`define SPD_CMD_NOP 3'h2
`define SPD_CMD_SP_EOI 3'h3
`define SPD_CMD_ROT_SET 3'h4
`define SPD_CMD_ROT_NS 3'h5
`define SPD_CMD_SET_PRI 3'h6
`define SPD_CMD_ROT_SP 3'h7

`define SPD_SEQ_IDLE 2'h0
`define SPD_SEQ_W2 2'h1
`define SPD_SEQ_W3 2'h2
`define SPD_SEQ_W4 2'h3

`endif

// ==== rtl/spd_cmd_decode.v ====
// eoi and priority command decoder for operation word 2
// assumes data and strobe come from the same clock domain
`timescale 1ns/1ps
`include "spd_map.vh"

module spd_cmd_decode (
  input wire wr_op2_in,
  input wire [7:0] data_in,
  output reg rot_clr_out,
  output reg ns_eoi_out,
  output reg sp_eoi_out,
  output reg rot_set_out,
  output reg rot_ns_out,
  output reg set_pri_out,
  output reg rot_sp_out,
  output reg [7:0] level_onehot_out
);

  wire [2:0] cmd;
  wire [2:0] lvl;
  wire [7:0] lvl_hit;
  wire lvl_used;
  genvar gi;

  assign cmd = data_in[`SPD_CMD_HI:`SPD_CMD_LO];
  assign lvl = data_in[2:0];

  always @* begin
    rot_clr_out = 1'b0;
    ns_eoi_out = 1'b0;
    sp_eoi_out = 1'b0;
    rot_set_out = 1'b0;
    rot_ns_out = 1'b0;
    set_pri_out = 1'b0;
    rot_sp_out = 1'b0;
    if (wr_op2_in) begin
      case (cmd)
        `SPD_CMD_ROT_CLR: rot_clr_out = 1'b1;
        `SPD_CMD_NS_EOI: ns_eoi_out = 1'b1;
        `SPD_CMD_SP_EOI: sp_eoi_out = 1'b1;
        `SPD_CMD_ROT_SET: rot_set_out = 1'b1;
        `SPD_CMD_ROT_NS: rot_ns_out = 1'b1;
        `SPD_CMD_SET_PRI: set_pri_out = 1'b1;
        `SPD_CMD_ROT_SP: rot_sp_out = 1'b1;
        default: rot_clr_out = 1'b0; // no operation code
      endcase
    end
  end

  // -------------------------------------------------
  // level one-hot, only for specific commands and set priority
  // -------------------------------------------------
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_lvl
      assign lvl_hit[gi] = (lvl == gi);
    end
  endgenerate

  // only the specific commands and set priority name a line
  assign lvl_used = wr_op2_in & ((cmd == `SPD_CMD_SP_EOI) | (cmd == `SPD_CMD_SET_PRI)
    | (cmd == `SPD_CMD_ROT_SP));

  // one driver for the whole vector keeps the bits from splitting across processes
  always @* begin
    level_onehot_out = lvl_used ? lvl_hit : 8'h00;
  end

endmodule // spd_cmd_decode

// ==== test/spd_host.sv ====
// host model: one-cycle port strobes driven at the falling edge
// assumes the bench calls acc and nothing else drives these pins
`timescale 1ns/1ps
module spd_host(
  input wire mclk_in,
  output logic wr_out = 0,
  output logic rd_out = 0,
  output logic [15:0] addr_out = 0,
  output logic [7:0] data_out = 0
);
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    {wr_out, rd_out, addr_out, data_out} = {w, !w, a, d};
    @(negedge mclk_in);
    // released pins change, so a stale value cannot pass
    {wr_out, rd_out, addr_out, data_out} = {2'h0, ~a, ~d};
  endtask
endmodule // spd_host

// ==== test/spd_top_assertions.sv ====
// checker: port relations of spd_top
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module spd_chk(
  input wire mclk_in,
  input wire rst_b_in,
  input wire ce_in,
  input wire wr_stb_in,
  input wire [15:0] addr_in,
  input wire [7:0] wdata_in,
  input wire slave_cascade_enable_in,
  input wire [7:0] init_word_1_out,
  input wire [7:0] operation_word_2_out,
  input wire [7:0] operation_word_3_out,
  input wire init_busy_out,
  input wire [1:0] init_ptr_out,
  input wire sp_eoi_out,
  input wire [7:0] level_onehot_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  wire go = ce_in & wr_stb_in & slave_cascade_enable_in;
  wire wa = go & (addr_in == 16'h00a0);
  wire wb = go & (addr_in == 16'h00a1);
  wire ic4 = init_word_1_out[0];
  wire [2:0] lvl = wdata_in[2:0];
  property p_single_controller_flag; !init_word_1_out[1]; endproperty
  a_single_controller_flag: assert property (p_single_controller_flag) else $error("word1 bit1");
  property p_w1; wa && wdata_in[4] |=> init_ptr_out == 2'h1 && init_busy_out; endproperty
  a_w1: assert property (p_w1) else $error("word1 start");
  property p_o2; wa && wdata_in[4:3] == 2'h0 |=> operation_word_2_out == $past(wdata_in);
  endproperty
  a_o2: assert property (p_o2) else $error("op2 route");
  property p_o3; wa && wdata_in[4:3] == 2'h1 |=> operation_word_3_out == $past(wdata_in)
    && $stable(operation_word_2_out); endproperty
  a_o3: assert property (p_o3) else $error("op3 route");
  property p_adv; wb && init_ptr_out == 2'h1 |=> init_ptr_out == 2'h2; endproperty
  a_adv: assert property (p_adv) else $error("ptr step");
  property p_end; wb && init_ptr_out == 2'h2 |=> init_busy_out == $past(ic4)
    && init_ptr_out == {$past(ic4), $past(ic4)}; endproperty
  a_end: assert property (p_end) else $error("word4 skip");
  property p_byp; wr_stb_in && !slave_cascade_enable_in |=> $stable(init_ptr_out)
    && $stable(init_word_1_out); endproperty
  a_byp: assert property (p_byp) else $error("bypass");
  property p_cmd; wa && wdata_in[7:3] == 5'h0c |=> sp_eoi_out
    && level_onehot_out == 8'h01 << $past(lvl); endproperty
  a_cmd: assert property (p_cmd) else $error("specific eoi");
  c_w4: cover property (wb && init_ptr_out == 2'h3);
  c_byp: cover property (wr_stb_in && !slave_cascade_enable_in);
  c_cmd: cover property (wa && wdata_in[7:3] == 5'h0c);
endmodule // spd_chk
bind spd_top spd_chk chk_u(.mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
  .wr_stb_in(wr_stb_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .slave_cascade_enable_in(slave_cascade_enable_in), .init_word_1_out(init_word_1_out),
  .operation_word_2_out(operation_word_2_out), .operation_word_3_out(operation_word_3_out),
  .init_busy_out(init_busy_out), .init_ptr_out(init_ptr_out), .sp_eoi_out(sp_eoi_out),
  .level_onehot_out(level_onehot_out));

// ==== test/spd_top_bench.sv ====
// bench: host model drives spd_top, a bench model predicts every result
// assumes rtl/ on the include path
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module spd_top_bench;
  logic mclk_in = 0, rst_b_in = 0, ce_in = 1, slave_cascade_enable_in = 1;
  logic [7:0] request_register_in = 0, in_service_register_in = 0, o2 = 0, o3 = 0;
  logic [1:4][7:0] m;
  logic sm = 0;
  wire wr_stb_in, rd_stb_in, init_busy_out, poll_req_out, special_mask_out, rot_clr_out;
  wire ns_eoi_out, sp_eoi_out, rot_set_out, rot_ns_out, set_pri_out, rot_sp_out;
  wire [15:0] addr_in;
  wire [7:0] wdata_in, rdata_out, operation_word_2_out, operation_word_3_out, level_onehot_out;
  wire [7:0] init_word_1_out, init_word_2_out, init_word_3_out, init_word_4_out;
  wire [1:0] init_ptr_out;
  int n_fail = 0, tests_run = 0, cyc = 0, mp = 0, sel = 0;
  spd_host host_u(.mclk_in(mclk_in), .wr_out(wr_stb_in), .rd_out(rd_stb_in),
    .addr_out(addr_in), .data_out(wdata_in));
  spd_top dut_u(.mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .wr_stb_in(wr_stb_in), .rd_stb_in(rd_stb_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .slave_cascade_enable_in(slave_cascade_enable_in),
    .request_register_in(request_register_in),
    .in_service_register_in(in_service_register_in), .rdata_out(rdata_out),
    .init_word_1_out(init_word_1_out), .init_word_2_out(init_word_2_out),
    .init_word_3_out(init_word_3_out), .init_word_4_out(init_word_4_out),
    .operation_word_2_out(operation_word_2_out), .operation_word_3_out(operation_word_3_out),
    .init_busy_out(init_busy_out), .init_ptr_out(init_ptr_out),
    .special_mask_out(special_mask_out), .poll_req_out(poll_req_out),
    .rot_clr_out(rot_clr_out), .ns_eoi_out(ns_eoi_out), .sp_eoi_out(sp_eoi_out),
    .rot_set_out(rot_set_out), .rot_ns_out(rot_ns_out), .set_pri_out(set_pri_out),
    .rot_sp_out(rot_sp_out), .level_onehot_out(level_onehot_out));
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] e, el;
    logic [6:0] ep;
    logic ok;
    e = 8'h01 << d[7:5];
    ep = 0;
    el = 0;
    ok = ce_in && slave_cascade_enable_in && a == 16'h00a0;
    host_u.acc(1, a, d);
    if (ok && d[4]) begin
      m[1] = d & 8'hfd;
      mp = 1;
      if (!d[0]) m[4] = 8'h01;
    end else if (ok && d[3]) begin
      o3 = d;
      if (d[1]) sel = d[0];
      if (d[6]) sm = d[5];
    end else if (ok) begin
      o2 = d;
      ep = {e[7:3], e[1:0]};
      if (d[7:5] == 3 || d[7:5] > 5) el = 8'h01 << d[2:0];
    end else if (ce_in && slave_cascade_enable_in && a == 16'h00a1 && mp > 0) begin
      m[mp + 1] = d;
      mp = mp == 1 ? 2 : (mp == 2 && m[1][0]) ? 3 : 0;
    end
    `CHK({init_word_1_out, init_word_2_out, init_word_3_out, init_word_4_out}, m)
    `CHK({operation_word_2_out, operation_word_3_out, init_ptr_out, init_busy_out},
      {o2, o3, mp[1:0], mp > 0})
    `CHK({rot_sp_out, set_pri_out, rot_ns_out, rot_set_out, sp_eoi_out, ns_eoi_out,
      rot_clr_out, level_onehot_out, poll_req_out, special_mask_out},
      {ep, el, ok && d[4:2] == 3'h3, sm})
  endtask
  task automatic get(input logic [15:0] a);
    host_u.acc(0, a, 8'h00);
    `CHK(rdata_out, a != 16'h00a0 ? 8'h00 : sel ? in_service_register_in
      : request_register_in)
  endtask
  task automatic init(input logic [7:0] d1);
    put(16'h00a0, d1);
    put(16'h00a1, 8'($urandom));
    put(16'h00a1, 8'($urandom));
    if (d1[0]) put(16'h00a1, 8'($urandom));
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always #2 mclk_in = ~mclk_in;
  // ceiling well above the roughly 80 cycles the sequence needs
  always @(posedge mclk_in) if (++cyc > 2000) begin
    n_fail++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'h9b1d));
    m = {8'h14, 8'h00, 8'h00, 8'h01};
    repeat (8) @(negedge mclk_in);
    rst_b_in = 1;
    put(16'h00a1, 8'h00);
    init(8'h13);
    init(8'h1e);
    put(16'h00a1, 8'h5a);
    put(16'h00a0, 8'h11);
    put(16'h00a1, 8'h42);
    init(8'h10);
    for (int c = 0; c < 8; c++) put(16'h00a0, {3'(c), 2'h0, 3'($urandom)});
    for (int k = 10; k < 12; k++) begin
      {request_register_in, in_service_register_in} = 16'($urandom);
      put(16'h00a0, 8'(k));
      get(16'h00a0);
      get(16'h00a2);
    end
    put(16'h00a0, 8'h6c);
    put(16'h00a0, 8'h48);
    slave_cascade_enable_in = 0;
    init(8'h11);
    ce_in = 0;
    slave_cascade_enable_in = 1;
    put(16'h00a0, 8'h04);
    end_of_test;
  end
endmodule // spd_top_bench
